// ---- rtl/usb_endpoint_flags_and_buffers.sv ----
// Notes on behaviour
// - Successful USB action sets handshake-ok flag
// - Failed USB action sets handshake-fail flag
// - Read direction, USB count differs from length: mismatch flag
// - No buffer for USB core: unavailable flag
// - CPU reads empty or writes full: bad access
// - CPU write in USB write direction: bad
// - Read direction: CPU quota written, buffer full
// - Write direction: CPU read count, buffer empty
// - Read direction: USB fetched count, buffer empty
// - Write direction: USB stored count, buffer full
// - Dual buffer may raise both done flags
// - Single buffer page from select bit
// - SETUP token goes page 0, 00-07
// - Start address from base bits 3:0
// - Length bits 0-6, locked during initialization
// - Low-speed signalling at 1.5 Mbit/s
// - Low speed: control plus two interrupt endpoints
// - Low speed packets at most 8 bytes
// - Polling interval 10 to 255 ms
// - Low speed uses a separate register set; here the endpoint registers are hidden instead (read 0, writes ignored)
// - Reading flag register clears its flags
// - Interrupt needs all four enables set
// - Flag reset 11h endpoint 0, 10h others
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep_defines.svh"
module usb_endpoint_flags_and_buffers #(
   parameter int N_EP      = 5,
   parameter int MS_CYCLES = `MS_CYCLES
) (
   input  wire logic           ref_clk,
   input  wire logic           reset_n,
   input  wire logic [7:0]     sfr_addr,
   input  wire logic           sfr_wr,
   input  wire logic           sfr_rd,
   input  wire logic [7:0]     sfr_wdata,
   output var  logic [7:0]     sfr_rdata,
   input  wire logic [2:0]     endpoint_selector,
   input  wire logic [N_EP-1:0] direction_bit,
   input  wire logic           initialization_lock,
   input  wire logic           dual_buffer_mode,
   input  wire logic           low_speed,
   input  wire logic [N_EP-1:0] global_endpoint_request,
   input  wire logic           usb_endpoint_irq_enable,
   input  wire logic           global_irq_enable,
   input  wire logic           cpu_buf_wr,
   input  wire logic           cpu_buf_rd,
   input  wire logic [2:0]     usb_ep,
   input  wire logic           usb_ack,
   input  wire logic           usb_nack,
   input  wire logic           usb_buf_req,
   input  wire logic           usb_byte,
   input  wire logic           usb_end,
   input  wire logic           usb_setup,
   input  wire logic [7:0]     poll_interval,
   output logic [7:0]          usb_mem_addr,
   output logic                usb_mem_page,
   output logic [N_EP-1:0]     usb_buffer_full,
   output logic [N_EP-1:0]     endpoint_irq,
   output logic                ls_bit_tick,
   output logic                poll_due
);
   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic ep_live(input logic [2:0] e, input logic ls);
      ep_live = (32'(e) < N_EP) && (!ls || 32'(e) < `LS_EP_COUNT);
   endfunction

   // ****************************************
   // Per-endpoint state
   // ****************************************
   usb_ep_pkg::reg8_t   flags_reg  [N_EP];
   usb_ep_pkg::reg8_t   flags_next [N_EP];
   usb_ep_pkg::reg8_t   base_reg   [N_EP];
   usb_ep_pkg::reg8_t   base_next  [N_EP];
   usb_ep_pkg::count_t  len_reg    [N_EP];
   usb_ep_pkg::count_t  len_next   [N_EP];
   usb_ep_pkg::reg8_t   enab_reg   [N_EP];
   usb_ep_pkg::reg8_t   enab_next  [N_EP];
   usb_ep_pkg::count_t  cpu_cnt_reg  [N_EP];
   usb_ep_pkg::count_t  cpu_cnt_next [N_EP];
   usb_ep_pkg::count_t  usb_cnt_reg  [N_EP];
   usb_ep_pkg::count_t  usb_cnt_next [N_EP];
   usb_ep_pkg::count_t  xfer_reg   [N_EP];
   usb_ep_pkg::count_t  xfer_next  [N_EP];
   logic [N_EP-1:0]     full_reg;
   logic [N_EP-1:0]     full_next;
   logic [N_EP-1:0]     pp_reg;
   logic [N_EP-1:0]     pp_next;
   logic [N_EP-1:0]     irq_next;
   logic                regs_on;
   logic [7:0]          rdata_next;

   // Endpoint registers are the full-speed set, hidden in low speed
   assign regs_on = !low_speed;

   // Next values of every endpoint
   always_comb begin
      for (int e = 0; e < N_EP; e++) begin
         logic sel;
         logic usb_me;
         logic rd_dir;
         usb_ep_pkg::count_t cnt_inc;
         sel     = regs_on && (32'(endpoint_selector) == e);
         usb_me  = ep_live(usb_ep, low_speed) && (32'(usb_ep) == e);
         rd_dir  = (direction_bit[e] == usb_ep_pkg::DIR_USB_READ);
         cnt_inc = cpu_cnt_reg[e] + 7'h0_1;
         flags_next[e]   = flags_reg[e];
         base_next[e]    = base_reg[e];
         len_next[e]     = len_reg[e];
         enab_next[e]    = enab_reg[e];
         cpu_cnt_next[e] = cpu_cnt_reg[e];
         usb_cnt_next[e] = usb_cnt_reg[e];
         xfer_next[e]    = xfer_reg[e];
         full_next[e]    = full_reg[e];
         pp_next[e]      = pp_reg[e];
         // Read of the flag register clears it except the reserved bit; events below win
         if (sel && sfr_rd && hit(sfr_addr, `EP_FLAGS_OFS)) begin
            flags_next[e] = 8'h0_0;
            flags_next[e][`FLAG_RSV_BIT] = flags_reg[e][`FLAG_RSV_BIT];
         end
         if (sel && sfr_wr && hit(sfr_addr, `EP_BASE_OFS)) begin
            base_next[e] = sfr_wdata;
         end
         if (sel && sfr_wr && hit(sfr_addr, `EP_LENGTH_OFS) && !initialization_lock) begin
            len_next[e] = sfr_wdata[`LEN_FIELD_MSB:0];
         end
         if (sel && sfr_wr && hit(sfr_addr, `EP_ENABLES_OFS)) begin
            enab_next[e] = sfr_wdata;
         end
         // CPU access to the endpoint buffer
         if (sel && cpu_buf_wr) begin
            if (!rd_dir || full_reg[e]) begin
               flags_next[e][`FLAG_BAD_BIT] = 1'b1;
            end else if (cnt_inc >= len_reg[e]) begin
               flags_next[e][`FLAG_CPU_BIT] = 1'b1;
               full_next[e]    = 1'b1;
               cpu_cnt_next[e] = 7'h0_0;
            end else begin
               cpu_cnt_next[e] = cnt_inc;
            end
         end
         if (sel && cpu_buf_rd) begin
            if (rd_dir || !full_reg[e]) begin
               flags_next[e][`FLAG_BAD_BIT] = 1'b1;
            end else if (cnt_inc >= xfer_reg[e]) begin
               flags_next[e][`FLAG_CPU_BIT] = 1'b1;
               full_next[e]    = 1'b0;
               cpu_cnt_next[e] = 7'h0_0;
            end else begin
               cpu_cnt_next[e] = cnt_inc;
            end
         end
         // USB side events
         if (usb_me) begin
            if (usb_ack) begin
               flags_next[e][`FLAG_OK_BIT] = 1'b1;
            end
            if (usb_nack) begin
               flags_next[e][`FLAG_FAIL_BIT] = 1'b1;
            end
            if (usb_buf_req && (rd_dir ? !full_reg[e] : full_reg[e])) begin
               flags_next[e][`FLAG_UNAV_BIT] = 1'b1;
            end
            if (usb_byte) begin
               usb_cnt_next[e] = usb_cnt_reg[e] + 7'h0_1;
            end
            if (usb_end) begin
               usb_cnt_next[e] = 7'h0_0;
               xfer_next[e]    = usb_cnt_reg[e];
               flags_next[e][`FLAG_USB_BIT] = 1'b1;
               full_next[e]    = !rd_dir;
               if (dual_buffer_mode) begin
                  pp_next[e] = !pp_reg[e];
               end
               if (low_speed && 32'(usb_cnt_reg[e]) > `LS_MAX_PACKET) begin
                  flags_next[e][`FLAG_LEN_BIT] = 1'b1;
               end
               if (rd_dir && usb_cnt_reg[e] != len_reg[e]) begin
                  flags_next[e][`FLAG_LEN_BIT] = 1'b1;
               end
            end
         end
         irq_next[e] = (|(flags_next[e] & enab_next[e]))
                       && global_endpoint_request[e]
                       && usb_endpoint_irq_enable && global_irq_enable;
      end
   end

   // Register endpoint state
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int e = 0; e < N_EP; e++) begin
            flags_reg[e]   <= (e == 0) ? `FLAGS_RST_EP0 : `FLAGS_RST_EPN;
            base_reg[e]    <= `BASE_RST;
            len_reg[e]     <= `LENGTH_RST;
            enab_reg[e]    <= `ENABLES_RST;
            cpu_cnt_reg[e] <= 7'h0_0;
            usb_cnt_reg[e] <= 7'h0_0;
            xfer_reg[e]    <= 7'h0_0;
         end
         full_reg     <= '0;
         pp_reg       <= '0;
         endpoint_irq <= '0;
      end else begin
         for (int e = 0; e < N_EP; e++) begin
            flags_reg[e]   <= flags_next[e];
            base_reg[e]    <= base_next[e];
            len_reg[e]     <= len_next[e];
            enab_reg[e]    <= enab_next[e];
            cpu_cnt_reg[e] <= cpu_cnt_next[e];
            usb_cnt_reg[e] <= usb_cnt_next[e];
            xfer_reg[e]    <= xfer_next[e];
         end
         full_reg     <= full_next;
         pp_reg       <= pp_next;
         endpoint_irq <= irq_next;
      end
   end

   assign usb_buffer_full = full_reg;

   // ****************************************
   // Register read port
   // ****************************************
   // Read mux of the selected endpoint
   always_comb begin
      int s;
      s = 32'(endpoint_selector);
      rdata_next = 8'h0_0;
      if (regs_on && sfr_rd && s < N_EP) begin
         if (hit(sfr_addr, `EP_FLAGS_OFS)) begin
            rdata_next = flags_reg[s];
         end else if (hit(sfr_addr, `EP_BASE_OFS)) begin
            rdata_next = {base_reg[s][`BASE_PAGE_BIT], 3'h0, base_reg[s][`BASE_START_MSB:0]};
         end else if (hit(sfr_addr, `EP_LENGTH_OFS)) begin
            rdata_next = {1'b0, len_reg[s]};
         end else if (hit(sfr_addr, `EP_ENABLES_OFS)) begin
            rdata_next = enab_reg[s];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h0_0;
      end else begin
         sfr_rdata <= rdata_next;
      end
   end

   // ****************************************
   // USB memory address
   // ****************************************
   logic [7:0] addr_next;
   logic       page_next;

   // Buffer start plus running offset of the USB side
   always_comb begin
      int u;
      u = 32'(usb_ep) < N_EP ? 32'(usb_ep) : 0;
      if (usb_setup) begin
         addr_next = {5'h0_0, usb_cnt_reg[u][2:0]};
         page_next = 1'b0;
      end else begin
         addr_next = {1'b0, base_reg[u][`BASE_START_MSB:0], 3'h0}
                     + {1'b0, usb_cnt_reg[u]};
         page_next = dual_buffer_mode ? pp_reg[u]
                                      : base_reg[u][`BASE_PAGE_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         usb_mem_addr <= 8'h0_0;
         usb_mem_page <= 1'b0;
      end else begin
         usb_mem_addr <= addr_next;
         usb_mem_page <= page_next;
      end
   end

   // ****************************************
   // Low-speed bit rate and polling timer
   // ****************************************
   localparam logic [15:0] RATE_STEP = 16'(`LS_RATE_KBPS / 500);
   localparam logic [15:0] RATE_MOD  = 16'(`CLK_RATE_KHZ / 500);
   logic [15:0] acc_reg;
   logic [15:0] acc_next;
   logic        tick_next;
   logic [31:0] ms_reg;
   logic [31:0] ms_next;
   logic [7:0]  poll_reg;
   logic [7:0]  poll_next;
   logic        due_next;
   logic [7:0]  interval;

   // Fractional divider, 3 bits every 40 clocks
   always_comb begin
      acc_next  = acc_reg + RATE_STEP;
      tick_next = 1'b0;
      if (!low_speed) begin
         acc_next = 16'h0_0;
      end else if (acc_next >= RATE_MOD) begin
         acc_next  = acc_next - RATE_MOD;
         tick_next = 1'b1;
      end
   end

   // Interval clamped to the legal range
   assign interval = (32'(poll_interval) < `POLL_MIN_MS) ? 8'(`POLL_MIN_MS)
                                                         : poll_interval;

   // Millisecond counter and interval counter
   always_comb begin
      ms_next   = ms_reg + 32'h0000_0001;
      poll_next = poll_reg;
      due_next  = 1'b0;
      if (!low_speed) begin
         ms_next   = 32'h0000_0000;
         poll_next = 8'h0_0;
      end else if (ms_reg >= 32'(MS_CYCLES - 1)) begin
         ms_next   = 32'h0000_0000;
         poll_next = poll_reg + 8'h0_1;
         if (poll_reg + 8'h0_1 >= interval) begin
            poll_next = 8'h0_0;
            due_next  = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg     <= 16'h0_0;
         ls_bit_tick <= 1'b0;
         ms_reg      <= 32'h0000_0000;
         poll_reg    <= 8'h0_0;
         poll_due    <= 1'b0;
      end else begin
         acc_reg     <= acc_next;
         ls_bit_tick <= tick_next;
         ms_reg      <= ms_next;
         poll_reg    <= poll_next;
         poll_due    <= due_next;
      end
   end

endmodule
`default_nettype wire

// ---- rtl/usb_ep_defines.svh ----
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define EP_ENABLES_OFS   8'h0C_3
`define EP_FLAGS_OFS     8'h0C_4
`define EP_BASE_OFS      8'h0C_5
`define EP_LENGTH_OFS    8'h0C_6
// ****************************************
// Field positions of the flag register
// ****************************************
`define FLAG_OK_BIT      7
`define FLAG_FAIL_BIT    6
`define FLAG_LEN_BIT     5
`define FLAG_RSV_BIT     4
`define FLAG_UNAV_BIT    3
`define FLAG_BAD_BIT     2
`define FLAG_CPU_BIT     1
`define FLAG_USB_BIT     0
// ****************************************
// Field positions of base and length
// ****************************************
`define BASE_PAGE_BIT    7
`define BASE_START_MSB   3
`define LEN_FIELD_MSB    6
// ****************************************
// Reset values
// ****************************************
`define FLAGS_RST_EP0    8'h1_1
`define FLAGS_RST_EPN    8'h1_0
`define BASE_RST         8'h0_0
`define LENGTH_RST       7'h0_0
`define ENABLES_RST      8'h0_0
// ****************************************
// Low-speed figures
// ****************************************
`define LS_RATE_KBPS     1500
`define CLK_RATE_KHZ     20000
`define LS_EP_COUNT      3
`define LS_MAX_PACKET    8
`define POLL_MIN_MS      10
`define POLL_MAX_MS      255
`define MS_CYCLES        (`CLK_RATE_KHZ)
`endif

// ---- rtl/usb_ep_pkg.sv ----
`default_nettype none
package usb_ep_pkg;
   typedef logic [7:0] reg8_t;
   typedef logic [6:0] count_t;
   typedef enum logic {DIR_USB_WRITE, DIR_USB_READ} xfer_dir_t;
endpackage
`default_nettype wire

// ---- verif/usb_endpoint_flags_and_buffers_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_flags_and_buffers_bench;
   logic       ref_clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, poll_interval = 8'h0A;
   logic [2:0] endpoint_selector = 3'h0;
   logic [4:0] direction_bit = 5'h00, global_endpoint_request = 5'h1F;
   logic       initialization_lock = 1'b0, dual_buffer_mode = 1'b0, low_speed = 1'b0;
   logic       usb_endpoint_irq_enable = 1'b1, global_irq_enable = 1'b1;
   logic       cpu_buf_wr = 1'b0, cpu_buf_rd = 1'b0;
   logic [7:0] sfr_rdata, usb_mem_addr;
   logic [4:0] usb_buffer_full, endpoint_irq;
   logic [2:0] usb_ep;
   logic       usb_mem_page, ls_bit_tick, poll_due, usb_ack, usb_nack;
   logic       usb_buf_req, usb_byte, usb_end, usb_setup;
   int         miscompares = 0, samples_checked = 0;
   // ****************************************
   // Clock, design and far side
   // ****************************************
   always #25 ref_clk = ~ref_clk;
   usb_endpoint_flags_and_buffers #(.MS_CYCLES(20)) dut (.*);
   usb_host_model host (.*);
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle;
      @(posedge ref_clk) #2;
   endtask
   // Register access, read data taken the cycle after
   task automatic sfr(input logic w, input logic [7:0] a, input logic [2:0] ep,
                      input logic [7:0] d, input logic [7:0] exp);
      settle;
      sfr_addr = a;
      endpoint_selector = ep;
      sfr_wdata = d;
      sfr_wr = w;
      sfr_rd = ~w;
      settle;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      if (!w) check(sfr_rdata, exp);
   endtask
   task automatic cpu_op(input logic w, input int n);
      repeat (n) begin
         settle;
         cpu_buf_wr = w;
         cpu_buf_rd = ~w;
         settle;
         cpu_buf_wr = 1'b0;
         cpu_buf_rd = 1'b0;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      sfr(0, 8'hC4, 3'h0, 8'h00, 8'h11);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h10);
      sfr(0, 8'hC4, 3'h0, 8'h00, 8'h10);
      sfr(0, 8'hC5, 3'h1, 8'h00, 8'h00);
      sfr(0, 8'hC4, 3'h5, 8'h00, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_regs;
      sfr(1, 8'hC5, 3'h1, 8'h8A, 8'h00);
      sfr(0, 8'hC5, 3'h1, 8'h00, 8'h8A);
      sfr(1, 8'hC6, 3'h1, 8'h02, 8'h00);
      initialization_lock = 1'b1;
      sfr(1, 8'hC6, 3'h1, 8'h07, 8'h00);
      initialization_lock = 1'b0;
      sfr(0, 8'hC6, 3'h1, 8'h00, 8'h02);
      host.point(3'h1, 1'b0);
      repeat (2) settle;
      check(usb_mem_addr, 8'h50);
      check({7'h00, usb_mem_page}, 8'h01);
      host.point(3'h1, 1'b1);
      repeat (2) settle;
      check({usb_mem_addr[7:1], usb_mem_page}, 8'h00);
      host.point(3'h1, 1'b0);
      $display("register test done");
   endtask
   task automatic t_tx;
      direction_bit = 5'h02;
      cpu_op(1, 2);
      settle;
      check({7'h00, usb_buffer_full[1]}, 8'h01);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h12);
      cpu_op(1, 1);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h14);
      host.transfer(3'h1, 2);
      settle;
      check({7'h00, usb_buffer_full[1]}, 8'h00);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h11);
      host.transfer(3'h1, 1);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h31);
      host.pulse(3'h1, 2);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h18);
      host.pulse(3'h1, 4);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h90);
      host.pulse(3'h1, 3);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h50);
      $display("transmit test done");
   endtask
   task automatic t_rx;
      direction_bit = 5'h00;
      cpu_op(1, 1);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h14);
      host.transfer(3'h1, 3);
      settle;
      check({7'h00, usb_buffer_full[1]}, 8'h01);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h11);
      cpu_op(0, 3);
      settle;
      check({7'h00, usb_buffer_full[1]}, 8'h00);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h12);
      cpu_op(0, 1);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h14);
      check(sfr_rdata & 8'hEF, 8'h04);
      $display("receive test done");
   endtask
   task automatic t_irq;
      sfr(1, 8'hC3, 3'h1, 8'h80, 8'h00);
      host.pulse(3'h1, 4);
      settle;
      check({3'h0, endpoint_irq}, 8'h02);
      global_irq_enable = 1'b0;
      settle;
      check({3'h0, endpoint_irq}, 8'h00);
      global_irq_enable = 1'b1;
      global_endpoint_request = 5'h1D;
      settle;
      check({3'h0, endpoint_irq}, 8'h00);
      global_endpoint_request = 5'h1F;
      settle;
      check({3'h0, endpoint_irq}, 8'h02);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h90);
      $display("interrupt test done");
   endtask
   // Dual buffer: page follows the swap, select bit ignored
   task automatic t_dual;
      dual_buffer_mode = 1'b1;
      host.point(3'h1, 1'b0);
      repeat (2) settle;
      check({7'h00, usb_mem_page}, 8'h00);
      host.transfer(3'h1, 0);
      host.point(3'h1, 1'b0);
      repeat (2) settle;
      check({7'h00, usb_mem_page}, 8'h01);
      host.pulse(3'h1, 2);
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h19);
      dual_buffer_mode = 1'b0;
      $display("dual buffer test done");
   endtask
   task automatic t_low;
      int ticks;
      int polls;
      ticks = 0;
      polls = 0;
      poll_interval = 8'h03;
      low_speed = 1'b1;
      sfr(0, 8'hC4, 3'h0, 8'h00, 8'h00);
      repeat (250) settle;
      repeat (400) begin
         settle;
         ticks += ls_bit_tick;
         polls += poll_due;
      end
      check(8'(ticks), 8'h1E);
      check(8'(polls), 8'h02);
      host.transfer(3'h1, 9);
      host.transfer(3'h4, 1);
      low_speed = 1'b0;
      sfr(0, 8'hC4, 3'h1, 8'h00, 8'h31);
      sfr(0, 8'hC4, 3'h4, 8'h00, 8'h10);
      $display("low speed test done");
   endtask
   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      #2 reset_n = 1'b1;
      t_reset;
      t_regs;
      t_tx;
      t_rx;
      t_irq;
      t_dual;
      t_low;
      summarize;
   end
   // Watchdog
   initial begin
      #(4000 * 50);
      miscompares++;
      summarize;
   end
endmodule
`default_nettype wire

// ---- verif/usb_endpoint_flags_and_buffers_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_flags_and_buffers_monitor #(
   parameter int N_EP      = 5,
   parameter int MS_CYCLES = 20000
) (
   input wire logic            ref_clk,
   input wire logic            reset_n,
   input wire logic [7:0]      sfr_addr,
   input wire logic            sfr_rd,
   input wire logic [7:0]      sfr_rdata,
   input wire logic [2:0]      endpoint_selector,
   input wire logic            low_speed,
   input wire logic [N_EP-1:0] global_endpoint_request,
   input wire logic            usb_endpoint_irq_enable,
   input wire logic            global_irq_enable,
   input wire logic            cpu_buf_wr,
   input wire logic            usb_end,
   input wire logic            usb_setup,
   input wire logic [7:0]      usb_mem_addr,
   input wire logic            usb_mem_page,
   input wire logic [N_EP-1:0] usb_buffer_full,
   input wire logic [N_EP-1:0] endpoint_irq,
   input wire logic            ls_bit_tick,
   input wire logic            poll_due
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ****************************************
   // Port relations
   // ****************************************
   hidden_regs_a: assert property (
      sfr_rd && low_speed |=> sfr_rdata == 8'h00) else $error("hidden register read nonzero");
   base_layout_a: assert property (
      sfr_rd && sfr_addr == 8'hC5 |=> sfr_rdata[6:4] == 3'b000) else $error("base gap bits set");
   len_layout_a: assert property (
      sfr_rd && sfr_addr == 8'hC6 |=> !sfr_rdata[7]) else $error("length bit 7 set");
   flag_reserved_a: assert property (
      sfr_rd && sfr_addr == 8'hC4 && !low_speed && endpoint_selector < 3'h5 |=> sfr_rdata[4])
      else $error("reserved flag bit lost");
   setup_page_a: assert property (
      usb_setup |=> !usb_mem_page && usb_mem_addr[7:3] == 5'h00) else $error("setup outside page 0");
   irq_gates_a: assert property (
      !(global_irq_enable && usb_endpoint_irq_enable) |=> endpoint_irq == '0)
      else $error("irq with gate closed");
   irq_request_a: assert property (
      (endpoint_irq & ~$past(global_endpoint_request)) == '0) else $error("irq without request bit");
   tick_gap_a: assert property (
      ls_bit_tick |=> !ls_bit_tick [*8]) else $error("bit ticks too close");
   tick_mode_a: assert property (
      !low_speed |=> !ls_bit_tick) else $error("bit tick outside low speed");
   poll_mode_a: assert property (
      !low_speed |=> !poll_due) else $error("poll outside low speed");
   full_cause_a: assert property (
      (usb_buffer_full & ~$past(usb_buffer_full)) != '0 |-> $past(cpu_buf_wr || usb_end))
      else $error("buffer full without cause");
endmodule
bind usb_endpoint_flags_and_buffers usb_endpoint_flags_and_buffers_monitor
   #(.N_EP(N_EP), .MS_CYCLES(MS_CYCLES)) mon (.*);
`default_nettype wire

// ---- verif/usb_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
   input  wire logic       ref_clk,
   output logic [2:0]      usb_ep,
   output logic            usb_ack,
   output logic            usb_nack,
   output logic            usb_buf_req,
   output logic            usb_byte,
   output logic            usb_end,
   output logic            usb_setup
);
   logic [4:0] ev;
   // Event lines: ok, fail, buffer request, byte, end
   assign {usb_ack, usb_nack, usb_buf_req, usb_byte, usb_end} = ev;
   initial begin
      ev = 5'h00;
      usb_ep = 3'h7;
      usb_setup = 1'b0;
   end
   // One event pulse, endpoint lines turned over afterwards
   task automatic pulse(input logic [2:0] ep, input int k);
      @(posedge ref_clk) #2;
      usb_ep = ep;
      ev[k] = 1'b1;
      @(posedge ref_clk) #2;
      ev = 5'h00;
      usb_ep = ~ep;
   endtask
   // Bytes then end of transfer
   task automatic transfer(input logic [2:0] ep, input int n);
      repeat (n) pulse(ep, 1);
      pulse(ep, 0);
   endtask
   // Point at an endpoint, optionally storing a setup token
   task automatic point(input logic [2:0] ep, input logic setup);
      @(posedge ref_clk) #2;
      usb_ep = ep;
      usb_setup = setup;
   endtask
endmodule
`default_nettype wire
